/* dmbx_defines.vh */
// Purpose: constants for the dual mailbox pair
// Assumes: 16-bit mailboxes, flag in the top bit
// Notes:   host register indices are plain word indices
`ifndef DMBX_DEFINES_VH
`define DMBX_DEFINES_VH
`define DMBX_FLAG_BIT      15
`define DMBX_MSG_HI        14
`define DMBX_MSG_W         15
`define DMBX_DATA_W        16
`define DMBX_ADDR_W        4
`define DMBX_ADR_BS_INBOX  4'h0
`define DMBX_ADR_SC_INBOX  4'h1
`define DMBX_ADR_IRQ_STAT  4'h2
`define DMBX_ADR_IRQ_MASK  4'h3
`define DMBX_ADR_STATUS    4'h4
`define DMBX_IRQ_W         2
`define DMBX_IRQ_BS_SET    0
`define DMBX_IRQ_SC_SET    1
`define DMBX_RST_MBOX      16'h0000
`define DMBX_RST_IRQ       2'h0
`define DMBX_CLK_PERIOD_PS 4000
`endif

/* dmbx_mailbox_pair.v */
// Purpose: two one-way mailboxes between bitstream processor and scalar unit
// Assumes: all ports synchronous to clk_i; one access per port per cycle
// Notes:   host writes act like the sending core's writes and set the flag
`timescale 1ns/1ps
`include "dmbx_defines.vh"

module dmbx_mailbox_pair #(
  parameter DATA_W = `DMBX_DATA_W,
  parameter ADDR_W = `DMBX_ADDR_W
) (
  // clock and reset
  input  wire              clk_i,
  input  wire              resetn_i,
  // scalar unit port
  input  wire              su_wr_i,
  input  wire [DATA_W-1:0] su_wdata_i,
  input  wire              su_rd_bs_i,
  input  wire              su_rd_sc_i,
  output wire [DATA_W-1:0] su_rdata_o,
  // bitstream processor port
  input  wire              bp_wr_i,
  input  wire [DATA_W-1:0] bp_wdata_i,
  input  wire              bp_rd_bs_i,
  input  wire              bp_rd_sc_i,
  output wire [DATA_W-1:0] bp_rdata_o,
  // host register port
  input  wire [ADDR_W-1:0] host_addr_i,
  input  wire [DATA_W-1:0] host_wdata_i,
  input  wire              host_wr_i,
  input  wire              host_rd_i,
  output wire [DATA_W-1:0] host_rdata_o,
  // interrupt and observation
  output wire              irq_o,
  output wire              bitstream_inbox_flag_out_o,
  output wire              scalar_inbox_flag_out_o
);

  // mailbox storage
  reg [`DMBX_MSG_W-1:0] bs_msg_r;
  reg [`DMBX_MSG_W-1:0] bs_msg_nxt;
  reg                   bs_flag_r;
  reg                   bs_flag_nxt;
  reg [`DMBX_MSG_W-1:0] sc_msg_r;
  reg [`DMBX_MSG_W-1:0] sc_msg_nxt;
  reg                   sc_flag_r;
  reg                   sc_flag_nxt;
  // interrupt state
  reg [`DMBX_IRQ_W-1:0] irq_stat_r;
  reg [`DMBX_IRQ_W-1:0] irq_stat_nxt;
  reg [`DMBX_IRQ_W-1:0] irq_mask_r;
  reg [`DMBX_IRQ_W-1:0] irq_mask_nxt;
  // read data registers
  reg [DATA_W-1:0]      su_rdata_r;
  reg [DATA_W-1:0]      su_rdata_nxt;
  reg [DATA_W-1:0]      bp_rdata_r;
  reg [DATA_W-1:0]      bp_rdata_nxt;
  reg [DATA_W-1:0]      host_rdata_r;
  reg [DATA_W-1:0]      host_rdata_nxt;

  wire [DATA_W-1:0] bs_word;
  wire [DATA_W-1:0] sc_word;
  wire              host_wr_bs;
  wire              host_wr_sc;
  wire              bs_set;
  wire              sc_set;
  wire              bs_clr;
  wire              sc_clr;
  wire              host_rd_stat;

  assign bs_word = {bs_flag_r, bs_msg_r};
  assign sc_word = {sc_flag_r, sc_msg_r};

  assign host_wr_bs   = host_wr_i && (host_addr_i == `DMBX_ADR_BS_INBOX);
  assign host_wr_sc   = host_wr_i && (host_addr_i == `DMBX_ADR_SC_INBOX);
  assign host_rd_stat = host_rd_i && (host_addr_i == `DMBX_ADR_IRQ_STAT);

  // host write data wins over a core write in the same cycle; the flag is set either way
  assign bs_set = su_wr_i || host_wr_bs;
  assign sc_set = bp_wr_i || host_wr_sc;
  assign bs_clr = bp_rd_bs_i;
  assign sc_clr = su_rd_sc_i;

  always @* begin
    bs_msg_nxt  = bs_msg_r;
    bs_flag_nxt = bs_flag_r;
    sc_msg_nxt  = sc_msg_r;
    sc_flag_nxt = sc_flag_r;
    if (host_wr_bs) begin
      bs_msg_nxt = host_wdata_i[`DMBX_MSG_HI:0];
    end else if (su_wr_i) begin
      bs_msg_nxt = su_wdata_i[`DMBX_MSG_HI:0];
    end
    if (host_wr_sc) begin
      sc_msg_nxt = host_wdata_i[`DMBX_MSG_HI:0];
    end else if (bp_wr_i) begin
      sc_msg_nxt = bp_wdata_i[`DMBX_MSG_HI:0];
    end
    // set listed last so it wins over a clear in the same cycle
    if (bs_clr) begin
      bs_flag_nxt = 1'b0;
    end
    if (bs_set) begin
      bs_flag_nxt = 1'b1;
    end
    if (sc_clr) begin
      sc_flag_nxt = 1'b0;
    end
    if (sc_set) begin
      sc_flag_nxt = 1'b1;
    end
  end

  // core read paths: reads of the own inbox see the flag before clearing
  always @* begin
    su_rdata_nxt = su_rdata_r;
    bp_rdata_nxt = bp_rdata_r;
    if (su_rd_sc_i) begin
      su_rdata_nxt = sc_word;
    end else if (su_rd_bs_i) begin
      su_rdata_nxt = bs_word;
    end
    if (bp_rd_bs_i) begin
      bp_rdata_nxt = bs_word;
    end else if (bp_rd_sc_i) begin
      bp_rdata_nxt = sc_word;
    end
  end

  // host registers; host reads of the mailboxes never touch the flags
  always @* begin
    host_rdata_nxt = {DATA_W{1'b0}};
    irq_mask_nxt   = irq_mask_r;
    irq_stat_nxt   = irq_stat_r;
    if (host_rd_stat) begin
      irq_stat_nxt = `DMBX_RST_IRQ;
    end
    // events set after the read-clear so none is lost
    if (bs_set) begin
      irq_stat_nxt[`DMBX_IRQ_BS_SET] = 1'b1;
    end
    if (sc_set) begin
      irq_stat_nxt[`DMBX_IRQ_SC_SET] = 1'b1;
    end
    if (host_wr_i && (host_addr_i == `DMBX_ADR_IRQ_MASK)) begin
      irq_mask_nxt = host_wdata_i[`DMBX_IRQ_W-1:0];
    end
    if (host_rd_i) begin
      case (host_addr_i)
        `DMBX_ADR_BS_INBOX: host_rdata_nxt = bs_word;
        `DMBX_ADR_SC_INBOX: host_rdata_nxt = sc_word;
        `DMBX_ADR_IRQ_STAT: host_rdata_nxt[`DMBX_IRQ_W-1:0] = irq_stat_r;
        `DMBX_ADR_IRQ_MASK: host_rdata_nxt[`DMBX_IRQ_W-1:0] = irq_mask_r;
        `DMBX_ADR_STATUS:   host_rdata_nxt[`DMBX_IRQ_W-1:0] = {sc_flag_r, bs_flag_r};
        default:            host_rdata_nxt = {DATA_W{1'b0}};
      endcase
    end
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bs_msg_r     <= {`DMBX_MSG_W{1'b0}};
      bs_flag_r    <= 1'b0;
      sc_msg_r     <= {`DMBX_MSG_W{1'b0}};
      sc_flag_r    <= 1'b0;
      irq_stat_r   <= `DMBX_RST_IRQ;
      irq_mask_r   <= `DMBX_RST_IRQ;
      su_rdata_r   <= `DMBX_RST_MBOX;
      bp_rdata_r   <= `DMBX_RST_MBOX;
      host_rdata_r <= `DMBX_RST_MBOX;
    end else begin
      bs_msg_r     <= bs_msg_nxt;
      bs_flag_r    <= bs_flag_nxt;
      sc_msg_r     <= sc_msg_nxt;
      sc_flag_r    <= sc_flag_nxt;
      irq_stat_r   <= irq_stat_nxt;
      irq_mask_r   <= irq_mask_nxt;
      su_rdata_r   <= su_rdata_nxt;
      bp_rdata_r   <= bp_rdata_nxt;
      host_rdata_r <= host_rdata_nxt;
    end
  end

  assign su_rdata_o                 = su_rdata_r;
  assign bp_rdata_o                 = bp_rdata_r;
  assign host_rdata_o               = host_rdata_r;
  assign irq_o                      = |(irq_stat_r & irq_mask_r);
  assign bitstream_inbox_flag_out_o = bs_flag_r;
  assign scalar_inbox_flag_out_o    = sc_flag_r;

endmodule

/* dmbx_cpu.sv */
// Purpose: model of the two cores on the mailbox ports
// Assumes: one strobe group per call, held for one edge
// Notes:   message kept in bits 14:0; released data inverted
`timescale 1ns/1ps
module dmbx_cpu (
  input  wire         clk_i,
  output logic [5:0]  stb_o,
  output logic [15:0] su_wd_o,
  output logic [15:0] bp_wd_o
);
  // stb_o: su_wr, su_rd_bs, su_rd_sc, bp_wr, bp_rd_bs, bp_rd_sc
  initial {stb_o, su_wd_o, bp_wd_o} = 38'h0;
  task core(input [5:0] s, input [14:0] m);
    @(posedge clk_i);
    stb_o   <= s;
    su_wd_o <= {1'h0, m};
    bp_wd_o <= {1'h0, m};
    @(posedge clk_i);
    stb_o   <= 6'h00;
    su_wd_o <= ~su_wd_o;
    bp_wd_o <= ~bp_wd_o;
    #1;
  endtask
endmodule

/* dmbx_chk.sv */
// Purpose: port checks for the mailbox pair
// Assumes: one clock, async active-low reset
// Notes:   flag outputs stand for stored bit 15
`timescale 1ns/1ps
module dmbx_chk #(parameter DATA_W = 16) (
  input wire              clk_i, resetn_i, su_wr_i, su_rd_bs_i, su_rd_sc_i, bp_wr_i,
  input wire              bp_rd_bs_i, bp_rd_sc_i, host_wr_i, host_rd_i, irq_o,
  input wire              bitstream_inbox_flag_out_o, scalar_inbox_flag_out_o,
  input wire [DATA_W-1:0] su_rdata_o, bp_rdata_o, host_rdata_o
);
  wire fb = bitstream_inbox_flag_out_o;
  wire fs = scalar_inbox_flag_out_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // a set in the same cycle wins, so clears are only checked alone
  sequence s_bs_take; bp_rd_bs_i && !su_wr_i && !host_wr_i; endsequence
  sequence s_sc_take; su_rd_sc_i && !bp_wr_i && !host_wr_i; endsequence
  property p_bs_set; su_wr_i |=> fb; endproperty
  a_bs_set: assert property (p_bs_set) else $error("bs flag not set");
  property p_sc_set; bp_wr_i |=> fs; endproperty
  a_sc_set: assert property (p_sc_set) else $error("sc flag not set");
  property p_bs_clr; s_bs_take |=> !fb; endproperty
  a_bs_clr: assert property (p_bs_clr) else $error("bs flag kept");
  property p_sc_clr; s_sc_take |=> !fs; endproperty
  a_sc_clr: assert property (p_sc_clr) else $error("sc flag kept");
  property p_bp_rd; bp_rd_bs_i |=> bp_rdata_o[15] == $past(fb); endproperty
  a_bp_rd: assert property (p_bp_rd) else $error("bp read flag");
  property p_su_rd; su_rd_sc_i |=> su_rdata_o[15] == $past(fs); endproperty
  a_su_rd: assert property (p_su_rd) else $error("su read flag");
  property p_keep; (su_rd_bs_i || bp_rd_sc_i || host_rd_i) && !bp_rd_bs_i && !su_rd_sc_i
    && !su_wr_i && !bp_wr_i && !host_wr_i |=> $stable(fb) && $stable(fs); endproperty
  a_keep: assert property (p_keep) else $error("read moved flag");
  property p_idle; !host_rd_i |=> host_rdata_o == 0; endproperty
  a_idle: assert property (p_idle) else $error("host data not idle");
  property p_rst; $rose(resetn_i) |-> !fb && !fs && !irq_o; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
endmodule
bind dmbx_mailbox_pair dmbx_chk #(.DATA_W(DATA_W)) dmbx_chk_i (.*);

/* dmbx_mailbox_pair_test.sv */
// Purpose: directed test of the mailbox pair
// Assumes: core strobes come from the core model
// Notes:   host reads double as flag probes
`timescale 1ns/1ps
module dmbx_mailbox_pair_test;
  logic        clk_i = 1'h0;
  logic        resetn_i = 1'h0;
  logic [3:0]  ha = 4'h0;
  logic [15:0] hd = 16'h0000;
  logic        hws = 1'h0;
  logic        hrs = 1'h0;
  wire  [5:0]  stb;
  wire  [15:0] sw, bw, sr, br, hq;
  wire         irq, fb, fs;
  int          failures = 0;
  int          checks_done = 0;
  int          cyc = 0;
  always #2 clk_i = ~clk_i;
  dmbx_cpu dmbx_cpu_i (.clk_i(clk_i), .stb_o(stb), .su_wd_o(sw), .bp_wd_o(bw));
  dmbx_mailbox_pair dmbx_mailbox_pair_i (.clk_i(clk_i), .resetn_i(resetn_i),
    .su_wr_i(stb[5]), .su_wdata_i(sw), .su_rd_bs_i(stb[4]), .su_rd_sc_i(stb[3]),
    .su_rdata_o(sr), .bp_wr_i(stb[2]), .bp_wdata_i(bw), .bp_rd_bs_i(stb[1]),
    .bp_rd_sc_i(stb[0]), .bp_rdata_o(br), .host_addr_i(ha), .host_wdata_i(hd),
    .host_wr_i(hws), .host_rd_i(hrs), .host_rdata_o(hq), .irq_o(irq),
    .bitstream_inbox_flag_out_o(fb), .scalar_inbox_flag_out_o(fs));
  task chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task hw(input [3:0] a, input [15:0] d);
    @(posedge clk_i);
    ha  <= a;
    hd  <= d;
    hws <= 1'h1;
    @(posedge clk_i);
    hws <= 1'h0;
    hd  <= ~d;
    #1;
  endtask
  task hr(input [3:0] a, input [15:0] e);
    @(posedge clk_i);
    ha  <= a;
    hrs <= 1'h1;
    @(posedge clk_i);
    hrs <= 1'h0;
    #1;
    chk(hq, e);
  endtask
  task results;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 1000) begin
      failures++;
      results;
    end
  end
  initial begin
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'h1;
    hr(4'h0, 16'h0000);
    dmbx_cpu_i.core(6'h20, 15'h1234);
    chk({14'h0, fs, fb}, 16'h0001);
    hr(4'h0, 16'h9234);
    dmbx_cpu_i.core(6'h10, 15'h0000);
    chk(sr, 16'h9234);
    dmbx_cpu_i.core(6'h02, 15'h0000);
    chk(br, 16'h9234);
    chk({14'h0, fs, fb}, 16'h0000);
    dmbx_cpu_i.core(6'h04, 15'h7FFF);
    dmbx_cpu_i.core(6'h01, 15'h0000);
    chk(br, 16'hFFFF);
    chk({14'h0, fs, fb}, 16'h0002);
    dmbx_cpu_i.core(6'h08, 15'h0000);
    chk(sr, 16'hFFFF);
    hr(4'h4, 16'h0000);
    dmbx_cpu_i.core(6'h22, 15'h0055);
    chk(br, 16'h1234);
    hr(4'h0, 16'h8055);
    chk({15'h0, irq}, 16'h0000);
    hw(4'h3, 16'h0003);
    hr(4'h3, 16'h0003);
    chk({15'h0, irq}, 16'h0001);
    hr(4'h2, 16'h0003);
    hr(4'h2, 16'h0000);
    chk({15'h0, irq}, 16'h0000);
    hw(4'h1, 16'h0ABC);
    hr(4'h1, 16'h8ABC);
    hw(4'h0, 16'h7FFF);
    hr(4'h0, 16'hFFFF);
    hw(4'hF, 16'h1111);
    hr(4'hF, 16'h0000);
    @(posedge clk_i);
    resetn_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'h1;
    hr(4'h1, 16'h0000);
    results;
  end
endmodule
